/* verilog/decode_pkg.sv */
// Shared constants and types for the instruction class decoder
package decode_pkg;
  localparam int INSTR_W = 32;
  localparam int ADDR_W = 32;
  localparam int REG_SEL_W = 5;
  localparam int REG_COUNT = 32;
  localparam int INSTR_BYTES = 4;
  localparam int ALIGN_BITS = 2;
  localparam int TGT_ENTRIES = 128;
  localparam int TGT_IDX_W = 7;
  localparam int TGT_TAG_W = ADDR_W - TGT_IDX_W - ALIGN_BITS;
  localparam logic [ALIGN_BITS-1:0] ALIGN_ZERO = 2'h0;
  localparam int DISP_W = 16;
  // Primary opcode, register and extended opcode field positions
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 26;
  localparam int RD_LO = 21;
  localparam int RA_LO = 16;
  localparam int RB_LO = 11;
  localparam int XO_HI = 10;
  localparam int XO_LO = 1;
  localparam int AXO_HI = 5;
  localparam int AXO_LO = 1;

  typedef enum logic [2:0] {
    CLS_INT = 3'h0,
    CLS_FP = 3'h1,
    CLS_LDST = 3'h2,
    CLS_FLOW = 3'h3,
    CLS_PCTL = 3'h4,
    CLS_MCTL = 3'h5,
    CLS_VEC = 3'h6,
    CLS_ILLEGAL = 3'h7
  } instr_class_t;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2,
    SZ_DOUBLE = 2'h3
  } operand_size_t;

  // Primary opcodes
  localparam logic [5:0] OP_TW = 6'h03;
  localparam logic [5:0] OP_VEC = 6'h04;
  localparam logic [5:0] OP_MULLI = 6'h07;
  localparam logic [5:0] OP_SUBFIC = 6'h08;
  localparam logic [5:0] OP_CMPLI = 6'h0A;
  localparam logic [5:0] OP_ADDIS = 6'h0F;
  localparam logic [5:0] OP_BC = 6'h10;
  localparam logic [5:0] OP_SC = 6'h11;
  localparam logic [5:0] OP_B = 6'h12;
  localparam logic [5:0] OP_CR = 6'h13;
  localparam logic [5:0] OP_RLW_LO = 6'h14;
  localparam logic [5:0] OP_RLW_HI = 6'h17;
  localparam logic [5:0] OP_ORI = 6'h18;
  localparam logic [5:0] OP_ANDIS = 6'h1D;
  localparam logic [5:0] OP_X = 6'h1F;
  localparam logic [5:0] OP_LWZ = 6'h20;
  localparam logic [5:0] OP_STMW = 6'h2F;
  localparam logic [5:0] OP_LFS = 6'h30;
  localparam logic [5:0] OP_STFDU = 6'h37;
  localparam logic [5:0] OP_FPS = 6'h3B;
  localparam logic [5:0] OP_FPD = 6'h3F;

  // Extended opcodes under OP_X
  localparam logic [9:0] XO_LWARX = 10'h014;
  localparam logic [9:0] XO_STWCX = 10'h096;
  localparam logic [9:0] XO_ECIWX = 10'h136;
  localparam logic [9:0] XO_ECOWX = 10'h1B6;
  localparam logic [9:0] XO_DCBA = 10'h2F6;
  localparam logic [9:0] XO_STFIWX = 10'h3D7;
  localparam logic [9:0] XO_TLBLD = 10'h3D2;
  localparam logic [9:0] XO_TLBLI = 10'h3F2;
  localparam logic [9:0] XO_DST = 10'h156;
  localparam logic [9:0] XO_DSTST = 10'h176;
  localparam logic [9:0] XO_LVXL = 10'h167;
  localparam logic [9:0] XO_STVXL = 10'h1E7;
  localparam logic [9:0] XO_MTSPR = 10'h1D3;
  localparam logic [9:0] XO_MFSPR = 10'h153;
  localparam logic [9:0] XO_SYNC = 10'h256;
  localparam logic [9:0] XO_EIEIO = 10'h356;
  localparam logic [9:0] XO_MTMSR = 10'h092;
  localparam logic [9:0] XO_MFMSR = 10'h053;
  localparam logic [9:0] XO_ICBI = 10'h3D6;
  localparam logic [9:0] XO_DCBF = 10'h056;
  localparam logic [9:0] XO_TLBIE = 10'h132;
  localparam logic [9:0] XO_MTSR = 10'h0D2;
  localparam logic [9:0] XO_TW = 10'h004;
  localparam logic [9:0] XO_ISYNC = 10'h096;
  // A-form extended opcodes for optional float ops
  localparam logic [4:0] AXO_FSEL = 5'h17;
  localparam logic [4:0] AXO_FRES = 5'h18;
  localparam logic [4:0] AXO_FRSQRTE = 5'h1A;
  // Bit of the stream-touch opcode that marks the transient form
  localparam int DST_T_BIT = 25;
endpackage : decode_pkg

/* verilog/branch_target_instr_cache_mem.sv */
// Branch target instruction cache storage with registered read
`timescale 1ns/1ps
module branch_target_instr_cache #(
  parameter int ENTRIES = decode_pkg::TGT_ENTRIES,
  parameter int IDX_W = decode_pkg::TGT_IDX_W,
  parameter int TAG_W = decode_pkg::TGT_TAG_W,
  parameter int DATA_W = decode_pkg::INSTR_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [TAG_W-1:0] wr_tag,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [IDX_W-1:0] rd_idx,
  input wire logic [TAG_W-1:0] rd_tag,
  output logic rd_hit,
  output logic [DATA_W-1:0] rd_data
);
  import decode_pkg::*;
  initial begin
    if (ENTRIES != (1 << IDX_W)) $error("ENTRIES must be 2**IDX_W");
  end
  logic [DATA_W-1:0] data_mem [ENTRIES];
  logic [TAG_W-1:0] tag_mem [ENTRIES];
  logic [ENTRIES-1:0] valid_r;
  // Storage arrays carry no reset
  always_ff @(posedge clk) begin
    if (wr_en) begin
      data_mem[wr_idx] <= wr_data;
      tag_mem[wr_idx] <= wr_tag;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      valid_r <= '0;
      rd_hit <= 1'b0;
      rd_data <= '0;
    end else begin
      if (wr_en) valid_r[wr_idx] <= 1'b1;
      rd_hit <= valid_r[rd_idx] && (tag_mem[rd_idx] == rd_tag);
      rd_data <= data_mem[rd_idx];
    end
  end
endmodule : branch_target_instr_cache

/* verilog/risc_instruction_class_decoder.sv */
// Instruction class decoder with address adder and target cache
`timescale 1ns/1ps
// Behaviour
// - Each instruction is one 32-bit word with fixed field positions.
// - Fetch addresses are word aligned; low two address bits are zero.
// - Integer loads/stores move byte, half or word to 32 general registers.
// - Float loads/stores move word or double word to 32 float registers.
// - Float computation uses single or double precision operands only.
// - Only load/store and vector classes may access memory; computation never writes.
// - Effective address adder uses 32-bit unsigned addition.
// - Carry out of the address top bit is dropped; address wraps.
// - Reservation load and conditional store are load/store class.
// - Vector indexed LRU load and store mark cache entries LRU.
// - Transient hint for transient stream touches and vector LRU ops.
// - Every base instruction is routed to hardware, none emulated.
// - Optional instructions listed are recognised as valid.
// - Page or block memory attributes travel with each access.
// - Cache lookups use physical addresses; write-back or through.
// - Branch unit has a 128-entry target cache answering on a hit.
module risc_instruction_class_decoder #(
  parameter int TGT_DEPTH = decode_pkg::TGT_ENTRIES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic in_valid,
  input wire logic [decode_pkg::INSTR_W-1:0] in_instr,
  input wire logic [decode_pkg::ADDR_W-1:0] in_pc,
  input wire logic [decode_pkg::ADDR_W-1:0] base_val,
  input wire logic [decode_pkg::ADDR_W-1:0] index_val,
  input wire logic wt_attr,
  input wire logic ci_attr,
  input wire logic coh_attr,
  input wire logic [decode_pkg::ADDR_W-1:0] phys_addr,
  input wire logic tgt_wr,
  input wire logic [decode_pkg::ADDR_W-1:0] tgt_wr_pc,
  input wire logic [decode_pkg::INSTR_W-1:0] tgt_wr_instr,
  output logic out_valid,
  output logic out_illegal,
  output decode_pkg::instr_class_t out_class,
  output logic [decode_pkg::INSTR_W-1:0] out_instr,
  output logic [decode_pkg::ADDR_W-1:0] out_pc,
  output logic [decode_pkg::REG_SEL_W-1:0] out_rd,
  output logic [decode_pkg::REG_SEL_W-1:0] out_ra,
  output logic [decode_pkg::REG_SEL_W-1:0] out_rb,
  output logic out_fp_reg,
  output logic out_mem_rd,
  output logic out_mem_wr,
  output decode_pkg::operand_size_t out_size,
  output logic [decode_pkg::ADDR_W-1:0] out_ea,
  output logic out_lru,
  output logic out_transient,
  output logic out_atomic,
  output logic out_wt,
  output logic out_ci,
  output logic out_coh,
  output logic [decode_pkg::ADDR_W-1:0] out_phys,
  output logic [decode_pkg::ADDR_W-1:0] next_fetch_pc,
  output logic tgt_hit,
  output logic [decode_pkg::INSTR_W-1:0] tgt_instr
);
  import decode_pkg::*;
  initial begin
    if (TGT_DEPTH != TGT_ENTRIES) $error("TGT_DEPTH must be 128");
  end

  typedef struct packed {
    logic valid;
    logic illegal;
    instr_class_t cls;
    logic [INSTR_W-1:0] instr;
    logic [ADDR_W-1:0] pc;
    logic fp_reg;
    logic mem_rd;
    logic mem_wr;
    operand_size_t size;
    logic [ADDR_W-1:0] ea;
    logic lru;
    logic transient;
    logic atomic;
    logic wt;
    logic ci;
    logic coh;
    logic [ADDR_W-1:0] phys;
    logic [ADDR_W-1:0] fetch_pc;
  } state_t;

  state_t st_r, st_nxt;

  // Decode of the X-form extended opcode, used for several outputs
  function automatic logic [9:0] xo_of(input logic [INSTR_W-1:0] w);
    xo_of = w[XO_HI:XO_LO];
  endfunction : xo_of

  function automatic logic [ADDR_W-1:0] ea_add(
    input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
    logic [ADDR_W:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    ea_add = sum[ADDR_W-1:0];
  endfunction : ea_add

  logic [5:0] opc;
  logic [9:0] xo;
  logic [4:0] axo;
  logic [ADDR_W-1:0] disp_ext;

  always_comb begin
    opc = in_instr[OPC_HI:OPC_LO];
    xo = xo_of(in_instr);
    axo = in_instr[AXO_HI:AXO_LO];
    disp_ext = {{(ADDR_W-DISP_W){in_instr[DISP_W-1]}},
                in_instr[DISP_W-1:0]};
    st_nxt = st_r;
    st_nxt.valid = in_valid;
    st_nxt.instr = in_instr;
    st_nxt.pc = {in_pc[ADDR_W-1:ALIGN_BITS], ALIGN_ZERO};
    st_nxt.fetch_pc = ea_add(st_nxt.pc, ADDR_W'(INSTR_BYTES));
    st_nxt.illegal = 1'b0;
    st_nxt.cls = CLS_INT;
    st_nxt.fp_reg = 1'b0;
    st_nxt.mem_rd = 1'b0;
    st_nxt.mem_wr = 1'b0;
    st_nxt.size = SZ_WORD;
    st_nxt.lru = 1'b0;
    st_nxt.transient = 1'b0;
    st_nxt.atomic = 1'b0;
    st_nxt.ea = ea_add(base_val, disp_ext);
    st_nxt.wt = wt_attr;
    st_nxt.ci = ci_attr;
    st_nxt.coh = coh_attr;
    st_nxt.phys = phys_addr;
    // All base opcodes map to a hardware class
    if (opc == OP_TW || opc == OP_SC || opc == OP_B || opc == OP_BC ||
        opc == OP_CR) begin
      st_nxt.cls = CLS_FLOW;
    end else if (opc == OP_VEC) begin
      st_nxt.cls = CLS_VEC;
    end else if ((opc >= OP_MULLI && opc <= OP_ADDIS) ||
                 (opc >= OP_RLW_LO && opc <= OP_RLW_HI && opc != 6'h16) ||
                 (opc >= OP_ORI && opc <= OP_ANDIS)) begin
      st_nxt.cls = CLS_INT;
    end else if (opc >= OP_LWZ && opc <= OP_STMW) begin
      st_nxt.cls = CLS_LDST;
      st_nxt.mem_wr = opc[2];
      st_nxt.mem_rd = !opc[2];
      st_nxt.size = !opc[3] ? (opc[1] ? SZ_BYTE : SZ_WORD) :
                    (opc[3:1] == 3'h7) ? SZ_WORD : SZ_HALF;
    end else if (opc >= OP_LFS && opc <= OP_STFDU) begin
      st_nxt.cls = CLS_LDST;
      st_nxt.fp_reg = 1'b1;
      st_nxt.mem_wr = opc[2];
      st_nxt.mem_rd = !opc[2];
      st_nxt.size = opc[1] ? SZ_DOUBLE : SZ_WORD;
    end else if (opc == OP_FPS || opc == OP_FPD) begin
      st_nxt.cls = CLS_FP;
      st_nxt.fp_reg = 1'b1;
      st_nxt.size = (opc == OP_FPS) ? SZ_WORD : SZ_DOUBLE;
      if (opc == OP_FPS && axo == AXO_FRES) st_nxt.size = SZ_WORD;
      if (opc == OP_FPD && (axo == AXO_FSEL || axo == AXO_FRSQRTE)) begin
        st_nxt.size = SZ_DOUBLE;
      end
    end else if (opc == OP_X) begin
      st_nxt.ea = ea_add(in_instr[RA_LO+:REG_SEL_W] == 5'h0 ? '0 : base_val,
                         index_val);
      unique case (xo)
        XO_LWARX: begin
          st_nxt.cls = CLS_LDST;
          st_nxt.mem_rd = 1'b1;
          st_nxt.atomic = 1'b1;
        end
        XO_STWCX: begin
          st_nxt.cls = CLS_LDST;
          st_nxt.mem_wr = 1'b1;
          st_nxt.atomic = 1'b1;
        end
        XO_ECIWX: begin
          st_nxt.cls = CLS_LDST;
          st_nxt.mem_rd = 1'b1;
        end
        XO_ECOWX: begin
          st_nxt.cls = CLS_LDST;
          st_nxt.mem_wr = 1'b1;
        end
        XO_STFIWX: begin
          st_nxt.cls = CLS_LDST;
          st_nxt.fp_reg = 1'b1;
          st_nxt.mem_wr = 1'b1;
        end
        XO_LVXL: begin
          st_nxt.cls = CLS_VEC;
          st_nxt.mem_rd = 1'b1;
          st_nxt.lru = 1'b1;
          st_nxt.transient = 1'b1;
        end
        XO_STVXL: begin
          st_nxt.cls = CLS_VEC;
          st_nxt.mem_wr = 1'b1;
          st_nxt.lru = 1'b1;
          st_nxt.transient = 1'b1;
        end
        XO_DST, XO_DSTST: begin
          st_nxt.cls = CLS_VEC;
          st_nxt.transient = in_instr[DST_T_BIT];
        end
        XO_DCBA, XO_TLBLD, XO_TLBLI, XO_ICBI, XO_DCBF, XO_TLBIE,
        XO_MTSR: begin
          st_nxt.cls = CLS_MCTL;
        end
        XO_MTSPR, XO_MFSPR, XO_SYNC, XO_EIEIO, XO_MTMSR,
        XO_MFMSR: begin
          st_nxt.cls = CLS_PCTL;
        end
        XO_TW: st_nxt.cls = CLS_FLOW;
        default: st_nxt.cls = CLS_INT;
      endcase
    end else begin
      st_nxt.cls = CLS_ILLEGAL;
      st_nxt.illegal = 1'b1;
    end
    if (st_nxt.illegal) begin
      st_nxt.mem_rd = 1'b0;
      st_nxt.mem_wr = 1'b0;
    end
    if (!in_valid) begin
      st_nxt.illegal = 1'b0;
      st_nxt.mem_rd = 1'b0;
      st_nxt.mem_wr = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) st_r <= '0;
    else st_r <= st_nxt;
  end

  branch_target_instr_cache #(
    .ENTRIES(TGT_DEPTH),
    .IDX_W(TGT_IDX_W),
    .TAG_W(TGT_TAG_W),
    .DATA_W(INSTR_W)
  ) u_tgt_cache (
    .clk(clk),
    .resetn(resetn),
    .wr_en(tgt_wr),
    .wr_idx(tgt_wr_pc[ALIGN_BITS+:TGT_IDX_W]),
    .wr_tag(tgt_wr_pc[ADDR_W-1:ALIGN_BITS+TGT_IDX_W]),
    .wr_data(tgt_wr_instr),
    .rd_idx(in_pc[ALIGN_BITS+:TGT_IDX_W]),
    .rd_tag(in_pc[ADDR_W-1:ALIGN_BITS+TGT_IDX_W]),
    .rd_hit(tgt_hit),
    .rd_data(tgt_instr)
  );

  assign out_valid = st_r.valid && !st_r.illegal;
  assign out_illegal = st_r.valid && st_r.illegal;
  assign out_class = st_r.cls;
  assign out_instr = st_r.instr;
  assign out_pc = st_r.pc;
  assign out_rd = st_r.instr[RD_LO+:REG_SEL_W];
  assign out_ra = st_r.instr[RA_LO+:REG_SEL_W];
  assign out_rb = st_r.instr[RB_LO+:REG_SEL_W];
  assign out_fp_reg = st_r.fp_reg;
  assign out_mem_rd = st_r.mem_rd;
  assign out_mem_wr = st_r.mem_wr;
  assign out_size = st_r.size;
  assign out_ea = st_r.ea;
  assign out_lru = st_r.lru;
  assign out_transient = st_r.transient;
  assign out_atomic = st_r.atomic;
  assign out_wt = st_r.wt;
  assign out_ci = st_r.ci;
  assign out_coh = st_r.coh;
  assign out_phys = st_r.phys;
  assign next_fetch_pc = st_r.fetch_pc;

  property p_align;
    @(posedge clk) disable iff (!resetn)
      out_pc[ALIGN_BITS-1:0] == ALIGN_ZERO && next_fetch_pc[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align) else $error("pc unaligned");

  property p_next_pc;
    @(posedge clk) disable iff (!resetn)
      (out_valid || out_illegal) |-> next_fetch_pc == out_pc + 32'h4;
  endproperty
  a_next_pc: assert property (p_next_pc) else $error("bad next pc");

  property p_mem_class;
    @(posedge clk) disable iff (!resetn)
      (out_mem_rd || out_mem_wr) |-> (out_class == CLS_LDST ||
                                      out_class == CLS_VEC);
  endproperty
  a_mem_class: assert property (p_mem_class) else $error("mem by compute");

  property p_lru_trans;
    @(posedge clk) disable iff (!resetn) out_lru |-> out_transient;
  endproperty
  a_lru_trans: assert property (p_lru_trans) else $error("lru not transient");

  property p_lvxl;
    @(posedge clk) disable iff (!resetn)
      (in_valid && in_instr[OPC_HI:OPC_LO] == OP_X &&
       in_instr[XO_HI:XO_LO] == XO_LVXL) |=> out_lru && out_mem_rd;
  endproperty
  a_lvxl: assert property (p_lvxl) else $error("lvx lru missed");

  property p_atomic;
    @(posedge clk) disable iff (!resetn)
      out_atomic && out_valid |-> out_class == CLS_LDST;
  endproperty
  a_atomic: assert property (p_atomic) else $error("atomic class");

  property p_illegal;
    @(posedge clk) disable iff (!resetn)
      out_illegal |-> !out_valid && !out_mem_rd && !out_mem_wr;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal dispatched");

  property p_fp_size;
    @(posedge clk) disable iff (!resetn)
      out_valid && out_class == CLS_FP |-> out_size inside {SZ_WORD, SZ_DOUBLE};
  endproperty
  a_fp_size: assert property (p_fp_size) else $error("fp size");

  property p_ea;
    @(posedge clk) disable iff (!resetn)
      in_valid && in_instr[OPC_HI:OPC_LO] == OP_LWZ |=>
      out_ea == $past(base_val) + {{16{$past(in_instr[15])}},
                                    $past(in_instr[15:0])};
  endproperty
  a_ea: assert property (p_ea) else $error("ea wrong");

  property p_attr;
    @(posedge clk) disable iff (!resetn)
      1'b1 |=> out_wt == $past(wt_attr) && out_ci == $past(ci_attr);
  endproperty
  a_attr: assert property (p_attr) else $error("attr lost");
endmodule : risc_instruction_class_decoder

/* bench/fetch_model.sv */
// Fetch-side model that presents instruction words to the decoder
`timescale 1ns/1ps
module fetch_model (
  input wire logic clk,
  output logic in_valid,
  output logic [decode_pkg::INSTR_W-1:0] in_instr,
  output logic [decode_pkg::ADDR_W-1:0] in_pc,
  output logic [decode_pkg::ADDR_W-1:0] base_val,
  output logic [decode_pkg::ADDR_W-1:0] index_val
);
  import decode_pkg::*;
  initial begin
    in_valid = 1'b0;
    in_instr = 32'h0;
    in_pc = 32'h0;
    base_val = 32'h0;
    index_val = 32'h0;
  end
  // One whole word per cycle, held until the next falling edge
  task automatic issue(input logic [31:0] w, input logic [31:0] pc,
                       input logic [31:0] b, input logic [31:0] x);
    in_valid = 1'b1;
    in_instr = w;
    in_pc = pc;
    base_val = b;
    index_val = x;
    @(negedge clk);
  endtask : issue
  // Released instruction and base lines show the inverse; pc and index lines keep the stale word
  task automatic idle();
    in_valid = 1'b0;
    in_instr = ~in_instr;
    base_val = ~base_val;
    @(negedge clk);
  endtask : idle
endmodule : fetch_model

/* bench/risc_instruction_class_decoder_test.sv */
// Self-checking bench for the instruction class decoder
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin \
  n_mismatch++; $display("ERROR t=%0t got %0h exp %0h", $time, a, e); \
  end end
module risc_instruction_class_decoder_test;
  import decode_pkg::*;
  int n_mismatch = 0;
  int total_checks = 0;
  logic clk, resetn, wt_attr, ci_attr, coh_attr, tgt_wr;
  logic in_valid, out_valid, out_illegal, out_fp_reg, out_mem_rd;
  logic out_mem_wr, out_lru, out_transient, out_atomic, out_wt, out_ci;
  logic out_coh, tgt_hit;
  logic [31:0] in_instr, in_pc, base_val, index_val, phys_addr;
  logic [31:0] tgt_wr_pc, tgt_wr_instr, out_instr, out_pc, out_ea;
  logic [31:0] out_phys, next_fetch_pc, tgt_instr;
  logic [4:0] out_rd, out_ra, out_rb;
  instr_class_t out_class;
  operand_size_t out_size;

  fetch_model fetch_model_inst (.clk(clk), .in_valid(in_valid),
    .in_instr(in_instr), .in_pc(in_pc), .base_val(base_val),
    .index_val(index_val));
  risc_instruction_class_decoder risc_instruction_class_decoder_inst (
    .clk(clk), .resetn(resetn), .in_valid(in_valid), .in_instr(in_instr),
    .in_pc(in_pc), .base_val(base_val), .index_val(index_val),
    .wt_attr(wt_attr), .ci_attr(ci_attr), .coh_attr(coh_attr),
    .phys_addr(phys_addr), .tgt_wr(tgt_wr), .tgt_wr_pc(tgt_wr_pc),
    .tgt_wr_instr(tgt_wr_instr), .out_valid(out_valid),
    .out_illegal(out_illegal), .out_class(out_class),
    .out_instr(out_instr), .out_pc(out_pc), .out_rd(out_rd),
    .out_ra(out_ra), .out_rb(out_rb), .out_fp_reg(out_fp_reg),
    .out_mem_rd(out_mem_rd), .out_mem_wr(out_mem_wr), .out_size(out_size),
    .out_ea(out_ea), .out_lru(out_lru), .out_transient(out_transient),
    .out_atomic(out_atomic), .out_wt(out_wt), .out_ci(out_ci),
    .out_coh(out_coh), .out_phys(out_phys),
    .next_fetch_pc(next_fetch_pc), .tgt_hit(tgt_hit),
    .tgt_instr(tgt_instr));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [31:0] d_form(logic [5:0] op, logic [4:0] rd,
                                         logic [4:0] ra, logic [15:0] d);
    return {op, rd, ra, d};
  endfunction : d_form
  function automatic logic [31:0] x_form(logic [9:0] xo, logic [4:0] rd);
    return {OP_X, rd, 5'h02, 5'h03, xo, 1'b0};
  endfunction : x_form
  function automatic logic [31:0] a_form(logic [5:0] op, logic [4:0] xo);
    return {op, 5'h01, 5'h02, 5'h03, 5'h04, xo, 1'b0};
  endfunction : a_form

  task automatic ls(instr_class_t c, logic r, logic w, operand_size_t s,
                    logic fp);
    `CHK(out_valid, 1'b1)
    `CHK(out_class, c)
    `CHK(out_mem_rd, r)
    `CHK(out_mem_wr, w)
    `CHK(out_size, s)
    `CHK(out_fp_reg, fp)
  endtask : ls

  task automatic t_load();
    logic [31:0] b [2] = '{32'hFFFF_FFF0, 32'h0000_0010};
    logic [15:0] d [2] = '{16'h0020, 16'hFFF0};
    logic [31:0] w;
    for (int i = 0; i < 2; i++) begin
      w = d_form(OP_LWZ, 5'h1F, 5'h01, d[i]);
      fetch_model_inst.issue(w, 32'hFFFF_FFFF, b[i], 32'h0);
      `CHK(out_ea, b[i] + {{16{d[i][15]}}, d[i]})
      `CHK(out_pc, 32'hFFFF_FFFC)
      `CHK(next_fetch_pc, 32'h0)
      `CHK(out_instr, w)
      `CHK(out_rd, 5'h1F)
      `CHK(out_ra, 5'h01)
      ls(CLS_LDST, 1'b1, 1'b0, SZ_WORD, 1'b0);
    end
    $display("t_load done");
  endtask : t_load

  task automatic t_sizes();
    logic [5:0] op [4] = '{6'h22, 6'h2C, OP_LFS, OP_STFDU};
    operand_size_t s [4] = '{SZ_BYTE, SZ_HALF, SZ_WORD, SZ_DOUBLE};
    for (int i = 0; i < 4; i++) begin
      fetch_model_inst.issue(d_form(op[i], 5'h04, 5'h05, 16'h0008),
                             32'h100, 32'h200, 32'h0);
      ls(CLS_LDST, i[0] == 1'b0, i[0], s[i], i[1]);
      `CHK(out_ea, 32'h208)
    end
    $display("t_sizes done");
  endtask : t_sizes

  task automatic t_atomic();
    fetch_model_inst.issue(x_form(XO_LWARX, 5'h07), 32'h40, 32'hFFFF_FFFF,
                           32'h2);
    `CHK(out_atomic, 1'b1)
    `CHK(out_ea, 32'h1)
    ls(CLS_LDST, 1'b1, 1'b0, SZ_WORD, 1'b0);
    fetch_model_inst.issue(x_form(XO_STWCX, 5'h07), 32'h44, 32'h10, 32'h4);
    `CHK(out_atomic, 1'b1)
    `CHK(out_ea, 32'h14)
    `CHK(out_pc, 32'h44)
    `CHK(out_rb, 5'h03)
    ls(CLS_LDST, 1'b0, 1'b1, SZ_WORD, 1'b0);
    $display("t_atomic done");
  endtask : t_atomic

  task automatic t_vector();
    logic [9:0] xo [5] = '{XO_LVXL, XO_STVXL, XO_DST, XO_DST, XO_DSTST};
    logic [4:0] rd [5] = '{5'h01, 5'h01, 5'h10, 5'h00, 5'h11};
    logic lru [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
    logic tr [5] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 5; i++) begin
      fetch_model_inst.issue(x_form(xo[i], rd[i]), 32'h80, 32'h0, 32'h0);
      `CHK(out_lru, lru[i])
      `CHK(out_transient, tr[i])
    end
    $display("t_vector done");
  endtask : t_vector

  task automatic t_classes();
    logic [31:0] opt [9] = '{x_form(XO_ECIWX, 5'h1), x_form(XO_ECOWX, 5'h1),
      x_form(XO_DCBA, 5'h0), x_form(XO_STFIWX, 5'h1),
      x_form(XO_TLBLD, 5'h0), x_form(XO_TLBLI, 5'h0),
      a_form(OP_FPD, AXO_FSEL), a_form(OP_FPS, AXO_FRES),
      a_form(OP_FPD, AXO_FRSQRTE)};
    logic [5:0] iop [4] = '{OP_MULLI, OP_ORI, OP_RLW_LO, OP_ADDIS};
    logic [31:0] cw [5] = '{x_form(XO_SYNC, 5'h0), x_form(XO_DCBF, 5'h0),
      x_form(XO_TW, 5'h0), d_form(OP_B, 5'h0, 5'h0, 16'h0),
      d_form(OP_VEC, 5'h0, 5'h0, 16'h0)};
    instr_class_t cc [5] = '{CLS_PCTL, CLS_MCTL, CLS_FLOW, CLS_FLOW,
      CLS_VEC};
    for (int i = 0; i < 9; i++) begin
      fetch_model_inst.issue(opt[i], 32'hC0, 32'h0, 32'h0);
      `CHK(out_valid, 1'b1)
      `CHK(out_illegal, 1'b0)
    end
    for (int i = 0; i < 4; i++) begin
      fetch_model_inst.issue(d_form(iop[i], 5'h3, 5'h4, 16'h5), 32'h0,
                             32'h0, 32'h0);
      `CHK(out_class, CLS_INT)
      `CHK(out_mem_wr, 1'b0)
      `CHK(out_mem_rd, 1'b0)
    end
    fetch_model_inst.issue(a_form(OP_FPD, 5'h15), 32'h0, 32'h0, 32'h0);
    `CHK(out_class, CLS_FP)
    `CHK(out_mem_wr, 1'b0)
    for (int i = 0; i < 5; i++) begin
      fetch_model_inst.issue(cw[i], 32'h0, 32'h0, 32'h0);
      `CHK(out_class, cc[i])
      `CHK(out_valid, 1'b1)
    end
    $display("t_classes done");
  endtask : t_classes

  task automatic t_illegal();
    fetch_model_inst.issue(32'h0000_1234, 32'h8, 32'h0, 32'h0);
    `CHK(out_illegal, 1'b1)
    `CHK(out_valid, 1'b0)
    `CHK(out_mem_rd, 1'b0)
    `CHK(out_mem_wr, 1'b0)
    fetch_model_inst.issue(d_form(OP_LWZ, 5'h2, 5'h3, 16'h4), 32'hC,
                           32'h0, 32'h0);
    `CHK(out_illegal, 1'b0)
    $display("t_illegal done");
  endtask : t_illegal

  task automatic t_attr();
    for (int i = 0; i < 2; i++) begin
      wt_attr = i[0];
      ci_attr = ~i[0];
      coh_attr = i[0];
      phys_addr = i[0] ? 32'h1234_5670 : 32'hEDCB_A980;
      fetch_model_inst.issue(d_form(OP_LWZ, 5'h2, 5'h3, 16'h4), 32'h10,
                             32'h0, 32'h0);
      `CHK(out_wt, i[0])
      `CHK(out_ci, ~i[0])
      `CHK(out_coh, i[0])
      `CHK(out_phys, phys_addr)
    end
    $display("t_attr done");
  endtask : t_attr

  task automatic t_tgt();
    tgt_wr = 1'b1;
    tgt_wr_pc = 32'h0000_01FC;
    tgt_wr_instr = 32'hA5A5_0F0F;
    @(negedge clk);
    tgt_wr = 1'b0;
    fetch_model_inst.issue(32'h0, 32'h0000_01FC, 32'h0, 32'h0);
    `CHK(tgt_hit, 1'b1)
    `CHK(tgt_instr, 32'hA5A5_0F0F)
    fetch_model_inst.issue(32'h0, 32'h0000_21FC, 32'h0, 32'h0);
    `CHK(tgt_hit, 1'b0)
    resetn = 1'b0;
    @(negedge clk);
    `CHK(out_valid, 1'b0)
    `CHK(tgt_hit, 1'b0)
    resetn = 1'b1;
    fetch_model_inst.issue(32'h0, 32'h0000_01FC, 32'h0, 32'h0);
    `CHK(tgt_hit, 1'b0)
    $display("t_tgt done");
  endtask : t_tgt

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : test_done

  initial begin
    #100000;
    n_mismatch++;
    test_done();
  end

  initial begin
    resetn = 1'b0;
    {wt_attr, ci_attr, coh_attr, tgt_wr} = 4'h0;
    phys_addr = 32'h0;
    tgt_wr_pc = 32'h0;
    tgt_wr_instr = 32'h0;
    repeat (20) @(negedge clk);
    `CHK(out_valid, 1'b0)
    `CHK(out_class, CLS_INT)
    resetn = 1'b1;
    @(negedge clk);
    t_load();
    t_sizes();
    t_atomic();
    fetch_model_inst.idle();
    t_vector();
    t_classes();
    t_illegal();
    fetch_model_inst.idle();
    t_attr();
    t_tgt();
    fetch_model_inst.idle();
    test_done();
  end
endmodule : risc_instruction_class_decoder_test
